// *** rtl/fspc_pkg.sv ***
// Constants and types of the flash self-programming controller
package fspc_pkg;
    localparam logic [15:0] ADDR_LO    = 16'hF090;
    localparam logic [15:0] ADDR_HI    = 16'hF091;
    localparam logic [15:0] DATA_LO    = 16'hF092;
    localparam logic [15:0] DATA_HI    = 16'hF093;
    localparam logic [15:0] ERASE_ADR  = 16'hF096;
    localparam logic [15:0] KEY_ADR    = 16'hF098;
    localparam logic [15:0] SEG_ADR    = 16'hF09A;
    localparam logic [15:0] EN_ADR     = 16'hF09C;
    localparam logic [15:0] STAT_ADR   = 16'hF09E;
    localparam logic [15:0] ADDR_RST   = 16'hFFFF;
    localparam logic [15:0] DATA_RST   = 16'hFFFF;
    localparam logic [15:0] RD_ZERO    = 16'h0000;
    localparam logic [4:0]  SEG_RST    = 5'h10;
    localparam logic [4:0]  SEG_CODE   = 5'h00;
    localparam logic [4:0]  SEG_DATA   = 5'h1F;
    localparam logic [7:0]  KEY_FIRST  = 8'hFA;
    localparam logic [7:0]  KEY_SECOND = 8'hF5;
    localparam logic [1:0]  CMD_BLOCK  = 2'h1;
    localparam logic [1:0]  CMD_SECTOR = 2'h2;
    localparam logic [15:0] CODE_BLOCK = 16'h4000;
    localparam logic [15:0] DATA_BLOCK = 16'h1000;
    localparam logic [15:0] CODE_SECT  = 16'h0400;
    localparam logic [15:0] DATA_SECT  = 16'h0080;
    localparam logic [15:0] CODE_UNIT  = 16'h0002;
    localparam logic [15:0] DATA_UNIT  = 16'h0001;
    localparam int STAT_PRG_BIT = 0;
    localparam int STAT_ERS_BIT = 1;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int CODE_PROG_MAX_NS = 60000;
    localparam int DATA_PROG_MAX_NS = 40000;
    localparam int ERASE_MAX_NS     = 50000000;
    localparam int CODE_PROG_CYC = CODE_PROG_MAX_NS / CLK_PERIOD_NS;
    localparam int DATA_PROG_CYC = DATA_PROG_MAX_NS / CLK_PERIOD_NS;
    localparam int ERASE_CYC     = ERASE_MAX_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 20;

    typedef enum logic [1:0] {
        FSPC_OP_PROG,
        FSPC_OP_SECTOR,
        FSPC_OP_BLOCK
    } fspc_op_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fspc_sfr_t;

    typedef struct packed {
        fspc_op_t    op;
        logic [4:0]  seg;
        logic [15:0] base;
        logic [15:0] len;
        logic [15:0] data;
        logic        two_bytes;
    } fspc_cmd_t;
endpackage

// *** rtl/fspc_ctrl.sv ***
// Flash self-programming controller: SFRs, unlock, sequencing, assertions
`timescale 1ns/10ps
`default_nettype none
module fspc_ctrl #(
    parameter int ERASE_CYCLES = fspc_pkg::ERASE_CYC
) (
    input  wire logic              clock_in,
    input  wire logic              resetn_in,
    input  wire fspc_pkg::fspc_sfr_t sfr_in,
    input  wire logic              sys_clk_low_in,
    input  wire logic              flash_done_in,
    output logic [15:0]            sfr_rdata_out,
    output logic                   flash_start_out,
    output fspc_pkg::fspc_cmd_t    flash_cmd_out,
    output logic                   cpu_stall_out,
    output logic                   nvm_done_out
);
    typedef enum logic [1:0] { KEY_IDLE, KEY_HALF, KEY_ARMED } fspc_key_t;
    typedef enum logic { RUN_IDLE, RUN_BUSY } fspc_run_t;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] byte_we(input fspc_pkg::fspc_sfr_t s,
                                           input logic [15:0] lo_a,
                                           input logic [15:0] hi_a);
        byte_we[0] = s.wr && s.addr == lo_a;
        byte_we[1] = s.wr && (s.word ? s.addr == lo_a : s.addr == hi_a);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [1:0] we,
                                          input fspc_pkg::fspc_sfr_t s);
        merge = old;
        if (we[0]) begin
            merge[7:0] = s.wdata[7:0];
        end
        if (we[1]) begin
            merge[15:8] = s.word ? s.wdata[15:8] : s.wdata[7:0];
        end
    endfunction

    function automatic logic [15:0] base_of(input logic [15:0] a,
                                            input logic [15:0] size);
        base_of = a & ~(size - 16'h0001);
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [15:0]         addr_r;
    logic [15:0]         data_r;
    logic [4:0]          seg_r;
    logic                en_r;
    logic                prg_busy_r;
    logic                ers_busy_r;
    logic                code_op_r;
    logic [fspc_pkg::TMR_W-1:0] tmr_r;
    logic [fspc_pkg::TMR_W-1:0] limit_nxt;
    fspc_key_t           key_r;
    fspc_run_t           run_r;
    logic [1:0]          addr_we;
    logic [1:0]          data_we;
    logic [15:0]         data_nxt;
    logic                is_code;
    logic                is_data;
    logic                prog_trig;
    logic                erase_wr;
    logic                erase_trig;
    logic                key_wr;
    logic                go;
    logic                op_end;
    fspc_pkg::fspc_cmd_t cmd_nxt;

    assign addr_we  = byte_we(sfr_in, fspc_pkg::ADDR_LO, fspc_pkg::ADDR_HI);
    assign data_we  = byte_we(sfr_in, fspc_pkg::DATA_LO, fspc_pkg::DATA_HI);
    assign data_nxt = merge(data_r, data_we, sfr_in);
    assign is_code  = seg_r == fspc_pkg::SEG_CODE;
    assign is_data  = seg_r == fspc_pkg::SEG_DATA;
    // High byte triggers program memory, low byte data flash
    assign prog_trig = is_code ? data_we[1] :
                       (is_data & data_we[0]);
    assign erase_wr = sfr_in.wr && sfr_in.addr == fspc_pkg::ERASE_ADR;
    assign erase_trig = erase_wr && (is_code || is_data) &&
        (sfr_in.wdata[1:0] == fspc_pkg::CMD_BLOCK ||
         sfr_in.wdata[1:0] == fspc_pkg::CMD_SECTOR);
    assign key_wr = sfr_in.wr && sfr_in.addr == fspc_pkg::KEY_ADR;
    // Needs the enable bit and an armed key
    assign go = (prog_trig || erase_trig) && en_r &&
                key_r == KEY_ARMED && run_r == RUN_IDLE;
    assign op_end = run_r == RUN_BUSY &&
                    (flash_done_in || tmr_r == '0);

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        cmd_nxt = '0;
        cmd_nxt.seg = seg_r;
        cmd_nxt.data = data_nxt;
        cmd_nxt.two_bytes = is_code;
        limit_nxt = fspc_pkg::TMR_W'(ERASE_CYCLES - 1);
        if (prog_trig) begin
            cmd_nxt.op = fspc_pkg::FSPC_OP_PROG;
            if (is_code) begin
                cmd_nxt.base = {addr_r[15:1], 1'b0};
                cmd_nxt.len = fspc_pkg::CODE_UNIT;
                limit_nxt = fspc_pkg::TMR_W'(fspc_pkg::CODE_PROG_CYC - 1);
            end else begin
                cmd_nxt.base = addr_r;
                cmd_nxt.len = fspc_pkg::DATA_UNIT;
                cmd_nxt.data[15:8] = 8'hFF;
                limit_nxt = fspc_pkg::TMR_W'(fspc_pkg::DATA_PROG_CYC - 1);
            end
        end else if (sfr_in.wdata[1:0] == fspc_pkg::CMD_SECTOR) begin
            cmd_nxt.op = fspc_pkg::FSPC_OP_SECTOR;
            cmd_nxt.len = is_code ? fspc_pkg::CODE_SECT :
                                    fspc_pkg::DATA_SECT;
            cmd_nxt.base = base_of(addr_r, cmd_nxt.len);
        end else begin
            cmd_nxt.op = fspc_pkg::FSPC_OP_BLOCK;
            cmd_nxt.len = is_code ? fspc_pkg::CODE_BLOCK :
                                    fspc_pkg::DATA_BLOCK;
            // Data flash has one block only, so its base is always zero
            cmd_nxt.base = is_code ? base_of(addr_r, cmd_nxt.len) :
                                     '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Address, data, segment and enable registers
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_r <= fspc_pkg::ADDR_RST;
            data_r <= fspc_pkg::DATA_RST;
        end else begin
            addr_r <= merge(addr_r, addr_we, sfr_in);
            data_r <= data_nxt;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            seg_r <= fspc_pkg::SEG_RST;
        end else if (sfr_in.wr && sfr_in.addr == fspc_pkg::SEG_ADR) begin
            seg_r <= sfr_in.wdata[4:0];
        end
    end

    // Low-speed clock cannot time the cells, so writes are dropped
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            en_r <= 1'b0;
        end else if (sfr_in.wr && sfr_in.addr == fspc_pkg::EN_ADR &&
                     !sys_clk_low_in) begin
            en_r <= sfr_in.wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Unlock key sequence
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            key_r <= KEY_IDLE;
        end else if (go) begin
            key_r <= KEY_IDLE;
        end else if (key_wr) begin
            if (sfr_in.wdata[7:0] == fspc_pkg::KEY_FIRST) begin
                key_r <= KEY_HALF;
            end else if (key_r == KEY_HALF) begin
                key_r <= (sfr_in.wdata[7:0] == fspc_pkg::KEY_SECOND) ?
                         KEY_ARMED : KEY_IDLE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Operation sequencer; timer bounds each operation
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_r <= RUN_IDLE;
            tmr_r <= '0;
            code_op_r <= 1'b0;
        end else begin
            unique case (run_r)
                RUN_IDLE: begin
                    if (go) begin
                        run_r <= RUN_BUSY;
                        tmr_r <= limit_nxt;
                        code_op_r <= is_code;
                    end
                end
                RUN_BUSY: begin
                    if (op_end) begin
                        run_r <= RUN_IDLE;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prg_busy_r <= 1'b0;
            ers_busy_r <= 1'b0;
        end else if (go && is_data) begin
            prg_busy_r <= prog_trig;
            ers_busy_r <= !prog_trig;
        end else if (op_end) begin
            prg_busy_r <= 1'b0;
            ers_busy_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flash_start_out <= 1'b0;
            flash_cmd_out <= '0;
            nvm_done_out <= 1'b0;
        end else begin
            flash_start_out <= go;
            if (go) begin
                flash_cmd_out <= cmd_nxt;
            end
            nvm_done_out <= op_end && !code_op_r;
        end
    end

    // CPU fetches from the array being written, so it must wait
    assign cpu_stall_out = run_r == RUN_BUSY && code_op_r;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sfr_rdata_out <= fspc_pkg::RD_ZERO;
        end else if (sfr_in.rd) begin
            unique case (sfr_in.addr)
                fspc_pkg::ADDR_LO: sfr_rdata_out <= sfr_in.word ? addr_r :
                                   {8'h00, addr_r[7:0]};
                fspc_pkg::ADDR_HI: sfr_rdata_out <= {8'h00, addr_r[15:8]};
                fspc_pkg::DATA_LO: sfr_rdata_out <= sfr_in.word ? data_r :
                                   {8'h00, data_r[7:0]};
                fspc_pkg::DATA_HI: sfr_rdata_out <= {8'h00, data_r[15:8]};
                fspc_pkg::SEG_ADR: sfr_rdata_out <= {11'h000, seg_r};
                fspc_pkg::EN_ADR:  sfr_rdata_out <= {15'h0000, en_r};
                fspc_pkg::STAT_ADR: sfr_rdata_out <= {14'h0000, ers_busy_r,
                                                      prg_busy_r};
                default: sfr_rdata_out <= fspc_pkg::RD_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_key_first;
        key_wr && sfr_in.wdata[7:0] == fspc_pkg::KEY_FIRST;
    endsequence
    sequence s_key_second;
        key_wr && sfr_in.wdata[7:0] == fspc_pkg::KEY_SECOND && !go;
    endsequence

    a_key_arms: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        s_key_first ##1 !key_wr ##1 s_key_second |=> key_r == KEY_ARMED)
        else $error("key pair did not arm");
    a_key_discard: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        s_key_first ##1 !key_wr ##1 (key_wr &&
        sfr_in.wdata[7:0] != fspc_pkg::KEY_SECOND &&
        sfr_in.wdata[7:0] != fspc_pkg::KEY_FIRST) |=> key_r == KEY_IDLE)
        else $error("bad second key kept unlock");
    a_unlock_once: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        flash_start_out |-> key_r == KEY_IDLE && $past(key_r) == KEY_ARMED)
        else $error("operation without or not consuming unlock");
    a_code_time: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        // Idle again at the latest one edge after the whole limit from launch
        go && prog_trig && is_code |-> ##[1:601] run_r == RUN_IDLE)
        else $error("program memory write overran");
    a_data_time: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        go && prog_trig && is_data |-> ##[1:401] run_r == RUN_IDLE)
        else $error("data flash write overran");
    a_prog_unit: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        go && prog_trig |=> flash_cmd_out.len == (is_code ? 16'h0002 : 16'h0001)
        && flash_cmd_out.base[0] == ($past(is_data) & $past(addr_r[0])))
        else $error("wrong program unit or address lsb");
    a_code_data: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        go && prog_trig && is_code |=> flash_cmd_out.data == $past(data_nxt))
        else $error("program memory data mismatch");
    a_block_base: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        flash_start_out && flash_cmd_out.op == fspc_pkg::FSPC_OP_BLOCK |->
        flash_cmd_out.base[13:0] == 14'h0000 &&
        (flash_cmd_out.seg == fspc_pkg::SEG_CODE || flash_cmd_out.base == '0))
        else $error("block base misaligned");
    a_erase_nop: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        erase_wr && (sfr_in.wdata[1:0] == 2'h0 ||
        sfr_in.wdata[1:0] == 2'h3) && !prog_trig |=> !flash_start_out)
        else $error("erase code 00 or 11 started work");
    a_erase_read: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        sfr_in.rd && sfr_in.addr == fspc_pkg::ERASE_ADR |=> sfr_rdata_out == '0)
        else $error("erase command read nonzero");
    a_en_locked: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        sfr_in.wr && sfr_in.addr == fspc_pkg::EN_ADR && sys_clk_low_in |=>
        $stable(en_r))
        else $error("enable written on low-speed clock");
    a_code_stall: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        go && is_code |=> cpu_stall_out until run_r == RUN_IDLE)
        else $error("program memory operation did not stall");
    a_done_event: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        op_end && !code_op_r |=> nvm_done_out && !prg_busy_r && !ers_busy_r)
        else $error("data flash completion missing");
endmodule // fspc_ctrl
`default_nettype wire

// *** bench/fspc_flash_model.sv ***
// Behavioural flash array that answers launched operations
`timescale 1ns/10ps
`default_nettype none
module fspc_flash_model (
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic        start_in,
    input  wire logic [11:0] delay_in,
    output logic             done_out
);
    logic [11:0] cnt_r;
    ////////////////////////////////////////////////////////////////////////
    // Long delays let the controller timer win; the late done then lands
    // while idle, which the controller must ignore
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r    <= 12'h000;
            done_out <= 1'b0;
        end else begin
            done_out <= (cnt_r == 12'h001);
            if (start_in) begin
                cnt_r <= delay_in;
            end else if (cnt_r != 12'h000) begin
                cnt_r <= cnt_r - 12'h001;
            end
        end
    end
endmodule // fspc_flash_model
`default_nettype wire

// *** bench/fspc_ctrl_tb_top.sv ***
// Self-checking bench for the flash self-programming controller
`timescale 1ns/10ps
`default_nettype none
module fspc_ctrl_tb_top;
    logic                clock_in;
    logic                resetn_in;
    fspc_pkg::fspc_sfr_t sfr_in;
    logic                sys_clk_low_in;
    logic                flash_done_in;
    logic [15:0]         sfr_rdata_out;
    logic                flash_start_out;
    fspc_pkg::fspc_cmd_t flash_cmd_out;
    logic                cpu_stall_out;
    logic                nvm_done_out;
    logic [11:0]         delay;
    fspc_pkg::fspc_cmd_t cap;
    int                  err_count = 0;
    int                  n_compared = 0;
    int                  n_start = 0;
    int                  n_done = 0;
    int                  i;
    int                  c;
    ////////////////////////////////////////////////////////////////////////
    fspc_ctrl #(.ERASE_CYCLES(50)) u_dut (
        .clock_in(clock_in), .resetn_in(resetn_in), .sfr_in(sfr_in),
        .sys_clk_low_in(sys_clk_low_in), .flash_done_in(flash_done_in),
        .sfr_rdata_out(sfr_rdata_out), .flash_start_out(flash_start_out),
        .flash_cmd_out(flash_cmd_out), .cpu_stall_out(cpu_stall_out),
        .nvm_done_out(nvm_done_out));
    fspc_flash_model u_flash (
        .clock_in(clock_in), .resetn_in(resetn_in),
        .start_in(flash_start_out), .delay_in(delay),
        .done_out(flash_done_in));
    always #50 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        if (flash_start_out === 1'b1) begin
            n_start <= n_start + 1;
            cap     <= flash_cmd_out;
        end
        if (nvm_done_out === 1'b1) begin
            n_done <= n_done + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    // Idle cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic w);
        sfr_in <= '{wr: 1'b1, rd: 1'b0, word: w, addr: a, wdata: d};
        @(negedge clock_in);
        sfr_in.wr <= 1'b0;
        @(negedge clock_in);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e,
                       input logic w, input string msg);
        sfr_in <= '{wr: 1'b0, rd: 1'b1, word: w, addr: a, wdata: 16'h0000};
        @(negedge clock_in);
        sfr_in.rd <= 1'b0;
        @(negedge clock_in);
        check((w ? sfr_rdata_out : {8'h00, sfr_rdata_out[7:0]}) === e, msg);
    endtask
    task automatic unlock();
        wr(fspc_pkg::KEY_ADR, 16'h00FA, 1'b0);
        wr(fspc_pkg::KEY_ADR, 16'h00F5, 1'b0);
    endtask
    task automatic trig(input logic [15:0] a, input logic [15:0] d,
                        input logic w, input int n, input string msg);
        int s;
        s = n_start;
        wr(a, d, w);
        repeat (2) @(negedge clock_in);
        check((n_start - s) == n, msg);
    endtask
    task automatic chk_cmd(input fspc_pkg::fspc_op_t op, input logic [4:0] sg,
                           input logic [15:0] b, input logic [15:0] l);
        check(cap.op === op && cap.seg === sg && cap.base === b
              && cap.len === l, "launch command");
    endtask
    // Callers wait for idle first, so no key or enable write hits a busy op
    task automatic wait_end(input int lim, input logic code);
        int d;
        d = n_done;
        for (i = 0; i < lim; i++) begin
            @(negedge clock_in);
            if (code ? cpu_stall_out === 1'b0 : n_done != d) break;
        end
        check(i < lim, "operation end");
        check((n_done - d) == (code ? 0 : 1), "done event");
        if (i >= lim) test_done();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        resetn_in = 1'b0;
        sfr_in = '0;
        sys_clk_low_in = 1'b0;
        delay = 12'h01E;
        repeat (12) @(negedge clock_in);
        resetn_in = 1'b1;
        @(negedge clock_in);
        rdc(fspc_pkg::ADDR_LO, 16'hFFFF, 1'b1, "addr reset");
        rdc(fspc_pkg::DATA_LO, 16'hFFFF, 1'b1, "data reset");
        rdc(fspc_pkg::SEG_ADR, 16'h0010, 1'b0, "seg reset");
        rdc(fspc_pkg::EN_ADR, 16'h0000, 1'b0, "en reset");
        rdc(fspc_pkg::STAT_ADR, 16'h0000, 1'b0, "stat reset");
        trig(fspc_pkg::ERASE_ADR, 16'h0001, 1'b0, 0, "locked");
        rdc(fspc_pkg::ERASE_ADR, 16'h0000, 1'b0, "cmd reads 0");
        rdc(fspc_pkg::KEY_ADR, 16'h0000, 1'b0, "key reads 0");
        wr(fspc_pkg::ADDR_HI, 16'h0012, 1'b0);
        wr(fspc_pkg::ADDR_LO, 16'h0035, 1'b0);
        rdc(fspc_pkg::ADDR_LO, 16'h1235, 1'b1, "addr bytes");
        // Segment 0x10 selects nothing; unlock survives
        wr(fspc_pkg::EN_ADR, 16'h0001, 1'b0);
        unlock();
        trig(fspc_pkg::DATA_LO, 16'hABCD, 1'b1, 0, "bad seg");
        wr(fspc_pkg::SEG_ADR, 16'h0000, 1'b0);
        trig(fspc_pkg::DATA_LO, 16'hABCD, 1'b1, 1, "code prog");
        check(cpu_stall_out === 1'b1, "stall");
        chk_cmd(fspc_pkg::FSPC_OP_PROG, 5'h00, 16'h1234, 16'h0002);
        check(cap.data === 16'hABCD && cap.two_bytes === 1'b1, "2B");
        wait_end(600, 1'b1);
        trig(fspc_pkg::DATA_HI, 16'h005A, 1'b0, 0, "reuse");
        // Other writes between the keys; slow array, timer ends the op
        delay = 12'hFA0;
        wr(fspc_pkg::KEY_ADR, 16'h00FA, 1'b0);
        wr(fspc_pkg::ADDR_LO, 16'h0041, 1'b0);
        wr(fspc_pkg::KEY_ADR, 16'h00F5, 1'b0);
        trig(fspc_pkg::DATA_HI, 16'h005A, 1'b0, 1, "high byte");
        check(cap.data === 16'h5ACD && cap.base === 16'h1240, "hb");
        wait_end(600, 1'b1);
        delay = 12'h01E;
        wr(fspc_pkg::KEY_ADR, 16'h00FA, 1'b0);
        wr(fspc_pkg::KEY_ADR, 16'h0033, 1'b0);
        wr(fspc_pkg::KEY_ADR, 16'h00F5, 1'b0);
        trig(fspc_pkg::DATA_LO, 16'h1111, 1'b1, 0, "bad key");
        // Program memory erases around address 0x1241
        unlock();
        trig(fspc_pkg::ERASE_ADR, 16'h0002, 1'b0, 1, "code sec");
        chk_cmd(fspc_pkg::FSPC_OP_SECTOR, 5'h00, 16'h1000,
                16'h0400);
        check(cpu_stall_out === 1'b1, "erase stall");
        wait_end(60, 1'b1);
        unlock();
        trig(fspc_pkg::ERASE_ADR, 16'h0001, 1'b0, 1, "code blk");
        chk_cmd(fspc_pkg::FSPC_OP_BLOCK, 5'h00, 16'h0000,
                16'h4000);
        wait_end(60, 1'b1);
        // Data flash: every erase code, erase before program
        wr(fspc_pkg::SEG_ADR, 16'h001F, 1'b0);
        wr(fspc_pkg::ADDR_LO, 16'h0F85, 1'b1);
        for (c = 0; c < 4; c++) begin
            unlock();
            trig(fspc_pkg::ERASE_ADR, 16'(c), 1'b0, int'(c == 1 || c == 2),
                 "erase code");
            if (c == 1 || c == 2) begin
                if (c == 1) chk_cmd(fspc_pkg::FSPC_OP_BLOCK, 5'h1F, 16'h0000,
                                    16'h1000);
                if (c == 2) chk_cmd(fspc_pkg::FSPC_OP_SECTOR, 5'h1F, 16'h0F80,
                                    16'h0080);
                rdc(fspc_pkg::STAT_ADR, 16'h0002, 1'b0, "ers busy");
                wait_end(60, 1'b0);
            end
        end
        unlock();
        trig(fspc_pkg::DATA_LO, 16'h7734, 1'b1, 1, "data prog");
        chk_cmd(fspc_pkg::FSPC_OP_PROG, 5'h1F, 16'h0F85, 16'h0001);
        check(cap.data === 16'hFF34 && cap.two_bytes === 1'b0, "1B");
        check(cpu_stall_out === 1'b0, "no stall");
        rdc(fspc_pkg::STAT_ADR, 16'h0001, 1'b0, "prg busy");
        wait_end(400, 1'b0);
        rdc(fspc_pkg::STAT_ADR, 16'h0000, 1'b0, "idle");
        unlock();
        trig(fspc_pkg::DATA_HI, 16'h0099, 1'b0, 0, "hi ignored");
        unlock();
        trig(fspc_pkg::DATA_LO, 16'h0056, 1'b0, 1, "low byte");
        wait_end(400, 1'b0);
        // Enable kept after ops, frozen on the slow clock
        sys_clk_low_in = 1'b1;
        wr(fspc_pkg::EN_ADR, 16'h0000, 1'b0);
        rdc(fspc_pkg::EN_ADR, 16'h0001, 1'b0, "en locked");
        sys_clk_low_in = 1'b0;
        wr(fspc_pkg::EN_ADR, 16'h0000, 1'b0);
        rdc(fspc_pkg::EN_ADR, 16'h0000, 1'b0, "en clear");
        unlock();
        trig(fspc_pkg::DATA_LO, 16'h0011, 1'b0, 0, "disabled");
        test_done();
    end
endmodule // fspc_ctrl_tb_top
`default_nettype wire
